//--- common/rmpu_pkg.sv
// Constants, register map and carrier types of the region protection unit.
// Assumes a 32-bit APB register bus and a same-clock access checker port.
package rmpu_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned NUM_REGIONS = 8;
	localparam logic [31:0] ADDR_CAP    = 32'hE000ED90;
	localparam logic [31:0] ADDR_CTRL   = 32'hE000ED94;
	localparam logic [31:0] ADDR_RSEL   = 32'hE000ED98;
	localparam logic [31:0] ADDR_BASE   = 32'hE000ED9C;
	localparam logic [31:0] ADDR_ATTR   = 32'hE000EDA0;
	localparam logic [31:0] ADDR_BASE1  = 32'hE000EDA4;
	localparam logic [31:0] ADDR_ATTR1  = 32'hE000EDA8;
	localparam logic [31:0] ADDR_BASE2  = 32'hE000EDAC;
	localparam logic [31:0] ADDR_ATTR2  = 32'hE000EDB0;
	localparam logic [31:0] ADDR_BASE3  = 32'hE000EDB4;
	localparam logic [31:0] ADDR_ATTR3  = 32'hE000EDB8;

	// Capability: instruction regions 0x00, data regions 0x08, unified.
	localparam logic [31:0] CAP_VALUE   = 32'h00000800;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_EN    = 0;
	localparam int CTRL_HFNMI = 1;
	localparam int CTRL_BG    = 2;
	localparam int BASE_VALID = 4;
	localparam int BASE_LSB   = 5;
	localparam int ATTR_EN    = 0;
	localparam int SIZE_LSB   = 1;
	localparam int SIZE_MSB   = 5;
	localparam int SRD_LSB    = 8;
	localparam int ATTR_B     = 16;
	localparam int ATTR_C     = 17;
	localparam int ATTR_S     = 18;
	localparam int TEX_LSB    = 19;
	localparam int TEX_MSB    = 21;
	localparam int AP_LSB     = 24;
	localparam int AP_MSB     = 26;
	localparam int ATTR_XN    = 28;
	localparam logic [31:0] ATTR_MASK = 32'h173FFF3F;

	// Size field limits and fixed system areas.
	localparam logic [4:0]  SIZE_MIN   = 5'h04;
	localparam logic [4:0]  SUBREG_MIN = 5'h07;
	localparam logic [5:0]  SUBREG_SH  = 6'h03;
	localparam logic [3:0]  REGION_NONE = 4'hF;
	localparam logic [31:0] SCS_FIRST  = 32'hE000E000;
	localparam logic [31:0] SCS_LAST   = 32'hE000EFFF;

	// Access permission codes.
	localparam logic [2:0] AP_PRIV_RW = 3'h1;
	localparam logic [2:0] AP_USER_RO = 3'h2;
	localparam logic [2:0] AP_FULL    = 3'h3;
	localparam logic [2:0] AP_PRIV_RO = 3'h5;
	localparam logic [2:0] AP_RO      = 3'h6;
	localparam logic [2:0] AP_RO_ALT  = 3'h7;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        priv;
		logic        fetch;
		logic        write;
		logic        hprio;
	} rmpu_req_s;

	typedef struct packed {
		logic       valid;
		logic       fault;
		logic       xn;
		logic       so;
		logic       shared;
		logic [3:0] region;
	} rmpu_rsp_s;

	typedef struct packed {
		logic                   ctrl_en;
		logic                   ctrl_hfnmi;
		logic                   ctrl_bg;
		logic [2:0]             rsel;
		logic [7:0][26:0]       base;
		logic [7:0][31:0]       attr;
		logic [31:0]            prdata;
		logic                   slverr;
		rmpu_rsp_s              rsp;
	} rmpu_state_s;

endpackage

//--- core/rmpu_top.sv
// Region protection unit: APB register file and access checker.
// Assumes requests come from core logic on pclk; no synchronisers needed.
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// (RULE1) Eight regions numbered 0 to 7 plus a background region.
// (RULE2) Overlapping enabled regions: highest-numbered match decides.
// (RULE3) Background region uses default map, privileged requests only.
// (RULE4) Fetches and data accesses share one set of regions.
// (RULE5) A prohibited access raises a memory management fault.
// (RULE6) Capability reads instr count 0x00, data count 0x08, unified.
// (RULE7) Control bit 0 enable, bit 1 handler check, bit 2 background.
// (RULE8) Disabled unit applies default map to every access.
// (RULE9) Enabled, no background: access outside all regions faults.
// (RULE10) Background map acts as region minus one, below all regions.
// (RULE11) Background bit ignored while the unit is disabled.
// (RULE12) Handler check off: no checking at priority -1 or -2.
// (RULE13) Handler check on: checking stays active in those handlers.
// (RULE14) Software never sets handler check while unit is disabled.
// (RULE15) Enabled with background: privileged miss uses default map.
// (RULE16) Enabled with background: unprivileged miss faults.
// (RULE17) System control space is always execute-never, strongly ordered.
// (RULE18) Enabled: system control space and vector table always allowed. Fetches from system control space still fault.
// (RULE19) Software enables a region before enabling without background.
// (RULE20) Background on, no regions: only privileged code runs.
// (RULE21) Strongly ordered areas are flagged in order and shared.
// (RULE22) Region select holds 0 to 7 and steers base and attributes.
// (RULE23) Region size is two to size plus one, least 32 bytes.
// (RULE24) Region matches when enabled and address in aligned block.
module rmpu_top #(
	parameter logic [31:0] VT_LAST = 32'h000003FF
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Access check
	input  wire rmpu_pkg::rmpu_req_s chk_req,
	output rmpu_pkg::rmpu_rsp_s      chk_rsp
);

	rmpu_pkg::rmpu_state_s q;
	rmpu_pkg::rmpu_state_s d;

	logic [7:0]  reg_match;                 // [RULE1]
	logic        any_hit;
	logic [2:0]  hit_idx;
	logic [31:0] hit_attr;
	logic        active;
	logic        in_scs;
	logic        in_vt;
	logic        ap_ok;
	logic        is_base;
	logic        is_attr;
	logic        mapped;
	logic [31:0] rd_val;
	logic [2:0]  wr_sel;

	// ****************************************************************
	// Region match
	// ****************************************************************
	// One matcher per region; a size of 31 shifts the mask to zero,
	// so that region covers the whole map.
	for (genvar g = 0; g < rmpu_pkg::NUM_REGIONS; g++) begin : g_reg
		logic [4:0]  sz;
		logic [5:0]  sh;
		logic [31:0] msk;
		logic [31:0] sw;
		logic        srd_off;
		assign sz  = q.attr[g][rmpu_pkg::SIZE_MSB:rmpu_pkg::SIZE_LSB];
		assign sh  = {1'b0, sz} + 6'h01;           // [RULE23]
		assign msk = 32'hFFFFFFFF << sh;
		assign sw  = chk_req.addr >> (sh - rmpu_pkg::SUBREG_SH);
		assign srd_off = (sz >= rmpu_pkg::SUBREG_MIN) &&
			q.attr[g][rmpu_pkg::SRD_LSB + int'(sw[2:0])];
		// Below the least size a region never matches.
		assign reg_match[g] = q.attr[g][rmpu_pkg::ATTR_EN] &&
			(sz >= rmpu_pkg::SIZE_MIN) && !srd_off &&
			(((chk_req.addr ^ {q.base[g], 5'h00}) & msk) == 32'h0); // [RULE24]
	end

	// Ascending scan, so the last hit is the highest number.
	always_comb begin
		any_hit = 1'b0;
		hit_idx = 3'h0;
		for (int i = 0; i < rmpu_pkg::NUM_REGIONS; i++) begin
			if (reg_match[i]) begin
				any_hit = 1'b1;
				hit_idx = 3'(i);                   // [RULE2]
			end
		end
	end

	// ****************************************************************
	// Permission decode
	// ****************************************************************
	// Fixed areas and the permission of the winning region.
	always_comb begin
		hit_attr = q.attr[hit_idx];
		in_scs = (chk_req.addr >= rmpu_pkg::SCS_FIRST) &&
			(chk_req.addr <= rmpu_pkg::SCS_LAST);
		in_vt  = chk_req.addr <= VT_LAST;
		active = q.ctrl_en &&
			!(chk_req.hprio && !q.ctrl_hfnmi);     // [RULE12] [RULE13]
		case (hit_attr[rmpu_pkg::AP_MSB:rmpu_pkg::AP_LSB])
			rmpu_pkg::AP_PRIV_RW: ap_ok = chk_req.priv;
			rmpu_pkg::AP_USER_RO: ap_ok = chk_req.priv || !chk_req.write;
			rmpu_pkg::AP_FULL:    ap_ok = 1'b1;
			rmpu_pkg::AP_PRIV_RO: ap_ok = chk_req.priv && !chk_req.write;
			rmpu_pkg::AP_RO,
			rmpu_pkg::AP_RO_ALT:  ap_ok = !chk_req.write;
			default:              ap_ok = 1'b0;
		endcase
	end

	// ****************************************************************
	// Register decode
	// ****************************************************************
	// Aliases reach the same selected region as the primary pair.
	always_comb begin
		is_base = (paddr == rmpu_pkg::ADDR_BASE) ||
			(paddr == rmpu_pkg::ADDR_BASE1) ||
			(paddr == rmpu_pkg::ADDR_BASE2) ||
			(paddr == rmpu_pkg::ADDR_BASE3);
		is_attr = (paddr == rmpu_pkg::ADDR_ATTR) ||
			(paddr == rmpu_pkg::ADDR_ATTR1) ||
			(paddr == rmpu_pkg::ADDR_ATTR2) ||
			(paddr == rmpu_pkg::ADDR_ATTR3);
		mapped = is_base || is_attr ||
			(paddr == rmpu_pkg::ADDR_CAP) ||
			(paddr == rmpu_pkg::ADDR_CTRL) ||
			(paddr == rmpu_pkg::ADDR_RSEL);
		rd_val = 32'h0;
		if (paddr == rmpu_pkg::ADDR_CAP) begin
			rd_val = rmpu_pkg::CAP_VALUE;           // [RULE6]
		end else if (paddr == rmpu_pkg::ADDR_CTRL) begin
			rd_val[rmpu_pkg::CTRL_EN]    = q.ctrl_en;
			rd_val[rmpu_pkg::CTRL_HFNMI] = q.ctrl_hfnmi;
			rd_val[rmpu_pkg::CTRL_BG]    = q.ctrl_bg;
		end else if (paddr == rmpu_pkg::ADDR_RSEL) begin
			rd_val[2:0] = q.rsel;
		end else if (is_base) begin
			// The valid bit always reads as zero.
			rd_val = {q.base[q.rsel], 2'h0, q.rsel};
		end else if (is_attr) begin
			rd_val = q.attr[q.rsel];
		end
		// A valid-flagged base write also moves the selection.
		wr_sel = pwdata[rmpu_pkg::BASE_VALID] ? pwdata[2:0] : q.rsel;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Read data is caught in the setup cycle so the access phase
	// needs no wait state; writes land at the access edge.
	always_comb begin
		d = q;
		if (psel && !penable) begin
			d.prdata = rd_val;
			d.slverr = !mapped;
		end
		if (psel && penable && pwrite) begin
			if (paddr == rmpu_pkg::ADDR_CTRL) begin     // [RULE7]
				d.ctrl_en    = pwdata[rmpu_pkg::CTRL_EN];
				d.ctrl_hfnmi = pwdata[rmpu_pkg::CTRL_HFNMI];
				d.ctrl_bg    = pwdata[rmpu_pkg::CTRL_BG];
			end else if (paddr == rmpu_pkg::ADDR_RSEL) begin
				d.rsel = pwdata[2:0];                   // [RULE22]
			end else if (is_base) begin
				d.rsel = wr_sel;
				d.base[wr_sel] = pwdata[31:rmpu_pkg::BASE_LSB];
			end else if (is_attr) begin
				d.attr[q.rsel] = pwdata & rmpu_pkg::ATTR_MASK;
			end
		end

		// One check path serves fetches and data alike.  [RULE4]
		d.rsp.valid  = chk_req.valid;
		d.rsp.region = any_hit ? {1'b0, hit_idx} : rmpu_pkg::REGION_NONE;
		d.rsp.fault  = 1'b0;
		d.rsp.xn     = 1'b0;
		d.rsp.so     = 1'b0;
		d.rsp.shared = 1'b0;
		if (!active) begin
			// Default map, background bit not consulted.  [RULE8] [RULE11]
			d.rsp.fault = 1'b0;
		end else if (in_scs || in_vt) begin
			d.rsp.fault = 1'b0;                          // [RULE18]
		end else if (any_hit) begin
			d.rsp.xn = hit_attr[rmpu_pkg::ATTR_XN];
			d.rsp.fault = !ap_ok ||
				(chk_req.fetch && hit_attr[rmpu_pkg::ATTR_XN]); // [RULE5]
			d.rsp.so = (hit_attr[rmpu_pkg::TEX_MSB:rmpu_pkg::TEX_LSB]
				== 3'h0) && !hit_attr[rmpu_pkg::ATTR_C] &&
				!hit_attr[rmpu_pkg::ATTR_B];
			// Device memory without cache bits is shared too.
			d.rsp.shared = d.rsp.so || hit_attr[rmpu_pkg::ATTR_S] ||
				(hit_attr[rmpu_pkg::TEX_MSB:rmpu_pkg::TEX_LSB] == 3'h0 &&
				!hit_attr[rmpu_pkg::ATTR_C]);            // [RULE21]
		end else begin
			// Miss: background only for privileged.  [RULE3] [RULE10]
			d.rsp.fault = !(q.ctrl_bg && chk_req.priv); // [RULE9] [RULE15] [RULE16] [RULE20]
		end
		// System control space is never executable nor reordered.
		if (in_scs) begin
			d.rsp.xn     = 1'b1;                         // [RULE17]
			d.rsp.so     = 1'b1;
			d.rsp.shared = 1'b1;
			d.rsp.fault  = chk_req.fetch;
		end
		d.rsp.fault = d.rsp.fault && chk_req.valid;
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// The unit and all regions come up disabled, so the unit starts transparent.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Zero wait states: pready is held high.
	assign pready  = 1'b1;
	assign prdata  = q.prdata;
	assign pslverr = q.slverr;
	assign chk_rsp = q.rsp;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic plain;
	assign plain = chk_req.valid && !in_scs && !in_vt;

	AST_LATENCY: assert property (chk_req.valid |=> chk_rsp.valid) // [RULE5]
		else $error("check answer missing one cycle after request");
	AST_OFF_PASS: assert property (chk_req.valid && !q.ctrl_en && !in_scs
		|=> !chk_rsp.fault) // [RULE8]
		else $error("fault raised while unit disabled");
	AST_NO_BG_MISS: assert property (plain && q.ctrl_en && !q.ctrl_bg &&
		!chk_req.hprio && reg_match == 8'h00 |=> chk_rsp.fault) // [RULE9]
		else $error("miss without background did not fault");
	AST_BG_PRIV: assert property (plain && q.ctrl_en && q.ctrl_bg &&
		chk_req.priv && reg_match == 8'h00 |=> !chk_rsp.fault) // [RULE15]
		else $error("privileged background access faulted");
	AST_BG_USER: assert property (plain && q.ctrl_en && q.ctrl_bg &&
		!chk_req.priv && !chk_req.hprio && reg_match == 8'h00
		|=> chk_rsp.fault) // [RULE16]
		else $error("unprivileged miss did not fault");
	AST_HANDLER: assert property (chk_req.valid && !in_scs &&
		chk_req.hprio && !q.ctrl_hfnmi |=> !chk_rsp.fault) // [RULE12]
		else $error("checking active in escalated handler");
	AST_SCS: assert property (chk_req.valid && in_scs
		|=> chk_rsp.xn && chk_rsp.so) // [RULE17]
		else $error("system control space attributes wrong");
	AST_TOP_WINS: assert property (chk_req.valid && reg_match[7]
		|=> chk_rsp.region == 4'h7) // [RULE2]
		else $error("highest region did not win");
	AST_CAP_READ: assert property (psel && !penable && !pwrite &&
		paddr == rmpu_pkg::ADDR_CAP |=> prdata == 32'h00000800) // [RULE6]
		else $error("capability read value wrong");
	AST_SEL_MOVE: assert property (psel && penable && pwrite && is_base &&
		pwdata[rmpu_pkg::BASE_VALID] |=> q.rsel == $past(pwdata[2:0])) // [RULE22]
		else $error("valid base write did not move selection");

	COV_FAULT: cover property (chk_rsp.valid && chk_rsp.fault);
	COV_OVERLAP: cover property (chk_req.valid && reg_match[0] &&
		reg_match[7]);
	COV_BG: cover property (plain && q.ctrl_en && q.ctrl_bg &&
		chk_req.priv && reg_match == 8'h00);
	COV_ALIAS: cover property (psel && penable && pwrite &&
		paddr == rmpu_pkg::ADDR_ATTR3);

endmodule

`default_nettype wire

//--- tb/rmpu_core_model.sv
// Model of the core side of the access check port: loads, stores, fetches.
// Assumes the unit answers one cycle after each request, on the same pclk.
`timescale 1ns/100ps
`default_nettype none
module rmpu_core_model (
	// Clock
	input  wire logic                pclk,
	// Access check
	output rmpu_pkg::rmpu_req_s      chk_req,
	input  wire rmpu_pkg::rmpu_rsp_s chk_rsp
);
	initial chk_req = '0;

	// One request stands for exactly one edge, then the answer is taken.
	// The idle address is inverted so that a stale value never looks valid.
	task automatic access(input logic [31:0] addr, input logic priv, fetch,
			hprio, wr, output rmpu_pkg::rmpu_rsp_s rsp);
		@(posedge pclk);
		chk_req <= '{valid: 1'b1, addr: addr, priv: priv, fetch: fetch,
			write: wr, hprio: hprio};
		@(posedge pclk);
		chk_req <= '{valid: 1'b0, addr: ~addr, priv: 1'b0, fetch: 1'b0,
			write: 1'b0, hprio: 1'b0};
		@(negedge pclk);
		rsp = chk_rsp;
	endtask
endmodule
`default_nettype wire

//--- tb/rmpu_top_tb_top.sv
// Self-checking testbench of the region protection unit.
// Assumes the package and the core model are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module rmpu_top_tb_top;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [31:0]         paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	rmpu_pkg::rmpu_req_s chk_req;
	rmpu_pkg::rmpu_rsp_s chk_rsp;
	int                  bad_count = 0;
	int                  n_checks = 0;

	rmpu_top i_rmpu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.chk_req(chk_req), .chk_rsp(chk_rsp));

	rmpu_core_model i_rmpu_core_model (.pclk(pclk), .chk_req(chk_req),
		.chk_rsp(chk_rsp));

	// Free-running 40 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Counts every comparison and reports a mismatch at once.
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic wr, input logic [31:0] a, d,
			output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready.
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [31:0] a, d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask

	task automatic rdc(input logic [31:0] a, exp);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h00000000, rd, e);
		check($sformatf("reg %h", a), rd, exp);
		check("slave error", {31'h0, e}, 32'h00000000);
	endtask

	// Attributes of a faulted access are left unchecked; region still is.
	task automatic acc_rw(input logic [31:0] a, input logic pv, fe, hp, wt,
			input logic [8:0] exp);
		rmpu_pkg::rmpu_rsp_s rsp;
		logic [8:0]          m;
		i_rmpu_core_model.access(a, pv, fe, hp, wt, rsp);
		m = exp[7] ? 9'h18F : 9'h1FF;
		check($sformatf("rsp %h", a), 32'(rsp & m), 32'(exp & m));
	endtask

	// Loads and fetches; stores go through acc_rw.
	task automatic acc(input logic [31:0] a, input logic pv, fe, hp,
			input logic [8:0] exp);
		acc_rw(a, pv, fe, hp, 1'b0, exp);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence: registers, disabled unit, enabled unit.
	initial begin
		logic [31:0] d;
		logic        e;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			rdc(rmpu_pkg::ADDR_CAP + 32'(4 * i),
				(i == 0) ? rmpu_pkg::CAP_VALUE : 32'h00000000);
		end
		wr(rmpu_pkg::ADDR_CAP, 32'hFFFFFFFF);
		rdc(rmpu_pkg::ADDR_CAP, 32'h00000800);
		apb(1'b0, 32'hE000EDBC, 32'h00000000, d, e);
		check("unmapped error", {31'h0, e}, 32'h00000001);
		wr(rmpu_pkg::ADDR_CTRL, 32'hFFFFFFFF); // enable set too
		rdc(rmpu_pkg::ADDR_CTRL, 32'h00000007);
		wr(rmpu_pkg::ADDR_CTRL, 32'h00000000);
		$display("test registers done");
		acc(32'h20000400, 1'b0, 1'b0, 1'b0, 9'h10F);
		acc(32'h20000000, 1'b0, 1'b1, 1'b0, 9'h10F);
		acc(32'hE000ED00, 1'b0, 1'b0, 1'b0, 9'h17F);
		wr(rmpu_pkg::ADDR_CTRL, 32'h00000004);
		acc(32'h20000400, 1'b0, 1'b0, 1'b0, 9'h10F);
		$display("test disabled done");
		// Region 0 is 1 KB full access, region 7 is 32 bytes privileged.
		wr(rmpu_pkg::ADDR_BASE, 32'h20000000);
		wr(rmpu_pkg::ADDR_ATTR, 32'h03000013);
		wr(rmpu_pkg::ADDR_BASE1, 32'h20000017);
		rdc(rmpu_pkg::ADDR_RSEL, 32'h00000007);
		wr(rmpu_pkg::ADDR_ATTR1, 32'h01000009);
		rdc(rmpu_pkg::ADDR_BASE, 32'h20000007);
		rdc(rmpu_pkg::ADDR_ATTR2, 32'h01000009);
		wr(rmpu_pkg::ADDR_CTRL, 32'h00000001); // regions first
		acc(32'h20000000, 1'b0, 1'b0, 1'b0, 9'h187);
		acc(32'h20000000, 1'b1, 1'b0, 1'b0, 9'h137);
		acc(32'h2000001F, 1'b0, 1'b0, 1'b0, 9'h187);
		acc(32'h20000020, 1'b0, 1'b0, 1'b0, 9'h130);
		acc(32'h200003FC, 1'b0, 1'b1, 1'b0, 9'h130);
		acc(32'h20000400, 1'b0, 1'b0, 1'b0, 9'h18F);
		acc(32'h20000400, 1'b1, 1'b0, 1'b0, 9'h18F);
		acc(32'hE000ED00, 1'b0, 1'b0, 1'b0, 9'h17F);
		acc(32'h00000100, 1'b0, 1'b0, 1'b0, 9'h10F);
		acc(32'h20000400, 1'b1, 1'b0, 1'b1, 9'h10F);
		wr(rmpu_pkg::ADDR_CTRL, 32'h00000003);
		acc(32'h20000400, 1'b1, 1'b0, 1'b1, 9'h18F);
		wr(rmpu_pkg::ADDR_CTRL, 32'h00000005);
		acc(32'h20000400, 1'b1, 1'b0, 1'b0, 9'h10F);
		acc(32'h20000400, 1'b0, 1'b0, 1'b0, 9'h18F);
		acc(32'h20000000, 1'b1, 1'b0, 1'b0, 9'h137);
		wr(rmpu_pkg::ADDR_ATTR, 32'h00000000);
		wr(rmpu_pkg::ADDR_RSEL, 32'h00000000);
		// Region 0 alone: user read-only, then read-only execute-never.
		wr(rmpu_pkg::ADDR_ATTR, 32'h02000013);
		acc_rw(32'h20000020, 1'b0, 1'b0, 1'b0, 1'b1, 9'h180);
		acc(32'h20000020, 1'b0, 1'b0, 1'b0, 9'h130);
		acc_rw(32'h20000020, 1'b1, 1'b0, 1'b0, 1'b1, 9'h130);
		wr(rmpu_pkg::ADDR_ATTR, 32'h16000013);
		acc(32'h20000020, 1'b1, 1'b1, 1'b0, 9'h180);
		acc(32'h20000020, 1'b1, 1'b0, 1'b0, 9'h170);
		acc_rw(32'h20000020, 1'b1, 1'b0, 1'b0, 1'b1, 9'h180);
		// Subregion 0 disabled: its first 128 bytes miss the region.
		wr(rmpu_pkg::ADDR_ATTR, 32'h03000113);
		acc(32'h20000020, 1'b0, 1'b0, 1'b0, 9'h18F);
		acc(32'h20000080, 1'b0, 1'b0, 1'b0, 9'h130);
		wr(rmpu_pkg::ADDR_ATTR3, 32'h00000000);
		acc(32'h20000020, 1'b0, 1'b1, 1'b0, 9'h18F);
		acc(32'h20000020, 1'b1, 1'b1, 1'b0, 9'h10F);
		$display("test enabled done");
		finish_test();
	end

	// Watchdog: the whole run needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		finish_test();
	end
endmodule
`default_nettype wire
